// ### rtl/fabric_cell_pkg.sv
package fabric_cell_pkg;

	// register map, byte addresses on the 32-bit bus
	localparam logic [7:0] OFF_LUT = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam int ADDR_BITS = 8;

	localparam logic [15:0] LUT_RST = 16'h0000;
	localparam logic [31:0] CFG_RST = 32'h0000_0400;

	// configuration word fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_BYPASS = 2;
	localparam int CFG_CASC_EN = 3;
	localparam int CFG_ACLR_LSB = 4;
	localparam int CFG_CLK_LSB = 7;
	localparam int CFG_SCLR_SRC = 9;
	localparam int CFG_DCLR_EN = 10;
	localparam int CFG_USED = 11;

	// status word fields
	localparam int STAT_Q = 0;
	localparam int STAT_COMB = 1;
	localparam int STAT_CARRY = 2;
	localparam int STAT_CASC = 3;
	localparam int STAT_UNKNOWN = 4;
	localparam int STAT_XTRA_LSB = 5;

	localparam logic [1:0] EMUL_EXTRA_CELLS = 2'h3;
	localparam int CELLS_PER_CLUSTER = 10;
	localparam int CHAIN_CLUSTER_STEP = 2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ARITH,
		MODE_COUNTER,
		MODE_CARRY_SINK
	} mode_e;

	typedef enum logic [2:0] {
		ACLR_NONE,
		ACLR_CLEAR,
		ACLR_PRESET,
		ACLR_PRESET_CLEAR,
		ACLR_LOAD
	} aclr_e;

	typedef enum logic [1:0] {
		CLK_LOCAL,
		CLK_GLOBAL,
		CLK_DEDICATED,
		CLK_OFF
	} clk_src_e;

	typedef struct packed {
		logic [3:0] data;
		logic carry_in;
		logic cascade_in;
	} cell_in_s;

	typedef struct packed {
		logic comb_out;
		logic reg_out;
		logic carry_out;
		logic cascade_out;
	} cell_out_s;

	typedef struct packed {
		logic clk_local;
		logic clk_global;
		logic clk_dedicated;
		logic clear_one;
		logic clear_two;
		logic sync_clear_local;
		logic sync_clear_global;
		logic sync_load;
	} cluster_ctl_s;

endpackage : fabric_cell_pkg

// ### rtl/fabric_logic_cell.sv
// Notes on behaviour
// - four-input table realises any function
// - one register plus carry and cascade links
// - chains run cells 1..10 and whole group
// - carry in feeds table and next stage
// - cross-cluster carry skips to alternate cluster
// - n-bit adder uses n+1 cells
// - register bypassed or used as accumulator
// - counter mode: two three-input functions
// - counter: load selector and clear gating
// - sync clear or load beats cascade
// - sync clear beats sync load
// - arithmetic mode shows registered and combinational
// - cluster lines drive clear; native async clear
// - cluster control from local, global, dedicated
// - cluster clears also async load and preset
// - sync clear from local or global
// - emulated preset or load costs three cells
// - emulated load undefined after device clear
// - device clear overrides every register control
// - preset registers set on device clear
`timescale 1ns/100ps
module fabric_logic_cell #(
	parameter int CELL_NUM = 1,
	parameter int CLUSTER_NUM = 0,
	parameter int CLUSTER_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire fabric_cell_pkg::cell_in_s cell_in,
	input wire fabric_cell_pkg::cluster_ctl_s cluster_ctl,
	input wire logic device_wide_clear_n,
	output fabric_cell_pkg::cell_out_s cell_out,
	output logic [3:0] carry_next_cell,
	output logic [CLUSTER_W-1:0] carry_next_cluster
);
	import fabric_cell_pkg::*;

	initial begin
		if (CELL_NUM < 1 || CELL_NUM > CELLS_PER_CLUSTER)
			$error("cell number out of range");
		if (CLUSTER_NUM < 0 || CLUSTER_NUM >= (1 << CLUSTER_W))
			$error("cluster number does not fit");
	end

	// bus slave
	logic [15:0] lut_r;
	logic [CFG_USED-1:0] cfg_r;
	logic [ADDR_BITS-1:0] addr_r;
	logic wr_pend_r;
	logic rd_pend_r;
	logic [31:0] status_w;

	wire addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
	wire wr_lut = wr_pend_r && addr_r == OFF_LUT;
	wire wr_cfg = wr_pend_r && addr_r == OFF_CFG;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_r <= '0;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			rd_pend_r <= addr_ok && !hwrite;
			if (addr_ok)
				addr_r <= haddr[ADDR_BITS-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lut_r <= LUT_RST;
			cfg_r <= CFG_RST[CFG_USED-1:0];
		end else begin
			if (wr_lut)
				lut_r <= hwdata[15:0];
			if (wr_cfg)
				cfg_r <= hwdata[CFG_USED-1:0];
		end
	end

	// unmapped offsets read as zero and ignore writes
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = !rd_pend_r ? 32'h0000_0000 :
		addr_r == OFF_LUT ? {16'h0000, lut_r} :
		addr_r == OFF_CFG ? {{(32-CFG_USED){1'b0}}, cfg_r} :
		addr_r == OFF_STAT ? status_w : 32'h0000_0000;

	// configuration decode
	wire mode_e mode = mode_e'(cfg_r[CFG_MODE_LSB +: 2]);
	wire aclr_e aclr_mode = aclr_e'(cfg_r[CFG_ACLR_LSB +: 3]);
	wire clk_src_e clk_src = clk_src_e'(cfg_r[CFG_CLK_LSB +: 2]);
	wire bypass = cfg_r[CFG_BYPASS];
	wire casc_en = cfg_r[CFG_CASC_EN];
	wire sclr_global = cfg_r[CFG_SCLR_SRC];
	wire dclr_en = cfg_r[CFG_DCLR_EN];

	// device clear pin crosses in through two flops
	logic dclr_meta_n_r;
	logic dclr_sync_n_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dclr_meta_n_r <= 1'b1;
			dclr_sync_n_r <= 1'b1;
		end else begin
			dclr_meta_n_r <= device_wide_clear_n;
			dclr_sync_n_r <= dclr_meta_n_r;
		end
	end
	wire dev_clear = dclr_en && !dclr_sync_n_r;

	// cluster clock enable and sync clear selection
	wire clk_en = clk_src == CLK_LOCAL ? cluster_ctl.clk_local :
		clk_src == CLK_GLOBAL ? cluster_ctl.clk_global :
		clk_src == CLK_DEDICATED ? cluster_ctl.clk_dedicated : 1'b0;
	wire sync_clear = sclr_global ? cluster_ctl.sync_clear_global :
		cluster_ctl.sync_clear_local;

	// table lookups; counter mode feeds the register back as first input
	logic q_r;
	wire a_in = mode == MODE_COUNTER ? q_r : cell_in.data[0];
	wire [3:0] idx4 = cell_in.data;
	wire [2:0] idx3 = {cell_in.carry_in, cell_in.data[1], a_in};
	wire lut4_out = lut_r[idx4];
	wire half_lo = lut_r[{1'b0, idx3}];
	wire half_hi = lut_r[{1'b1, idx3}];

	logic func_w;
	logic carry_w;
	always_comb begin
		unique case (mode)
			MODE_NORMAL: begin
				func_w = lut4_out;
				carry_w = cell_in.carry_in;
			end
			MODE_ARITH, MODE_COUNTER: begin
				func_w = half_lo;
				carry_w = half_hi;
			end
			MODE_CARRY_SINK: begin
				func_w = cell_in.carry_in;
				carry_w = 1'b0;
			end
		endcase
	end

	wire casc_w = casc_en ? (func_w & cell_in.cascade_in) : func_w;
	wire is_counter = mode == MODE_COUNTER;
	wire do_sclr = is_counter && sync_clear;
	wire do_sload = is_counter && cluster_ctl.sync_load;
	// clear gate sits after the load selector, so clear always wins
	wire load_sel = do_sload ? cell_in.data[2] : casc_w;
	wire d_w = do_sclr ? 1'b0 : load_sel;

	// cluster clear lines as async clear, preset, or load
	wire c1 = cluster_ctl.clear_one;
	wire c2 = cluster_ctl.clear_two;
	logic a_act;
	logic a_val;
	always_comb begin
		a_act = 1'b0;
		a_val = 1'b0;
		unique case (aclr_mode)
			ACLR_CLEAR: begin
				a_act = c1;
			end
			ACLR_PRESET: begin
				a_act = c2;
				a_val = 1'b1;
			end
			ACLR_PRESET_CLEAR: begin
				a_act = c1 || c2;
				a_val = !c1 && c2;
			end
			ACLR_LOAD: begin
				a_act = c1;
				a_val = cell_in.data[3];
			end
			default: begin
				a_act = 1'b0;
			end
		endcase
	end

	wire emulated = aclr_mode == ACLR_PRESET ||
		aclr_mode == ACLR_PRESET_CLEAR || aclr_mode == ACLR_LOAD;
	wire preset_kind = aclr_mode == ACLR_PRESET ||
		aclr_mode == ACLR_PRESET_CLEAR;
	// the preset is emulated by inversion, so device clear lands on one
	wire dclr_val = preset_kind;

	logic q_nxt;
	logic unknown_r;
	logic unknown_nxt;
	always_comb begin
		q_nxt = q_r;
		unknown_nxt = unknown_r;
		if (dev_clear) begin
			q_nxt = dclr_val;
			unknown_nxt = aclr_mode == ACLR_LOAD;
		end else if (a_act) begin
			q_nxt = a_val;
			unknown_nxt = 1'b0;
		end else if (clk_en) begin
			q_nxt = d_w;
			unknown_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_r <= 1'b0;
			unknown_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
			unknown_r <= unknown_nxt;
		end
	end

	// outputs: both versions at once for arithmetic use
	assign cell_out.comb_out = casc_w;
	assign cell_out.reg_out = bypass ? casc_w : q_r;
	assign cell_out.carry_out = carry_w;
	assign cell_out.cascade_out = casc_w;

	// chain position of the next stage
	localparam logic [3:0] LAST_CELL = 4'(CELLS_PER_CLUSTER);
	localparam logic [3:0] THIS_CELL = 4'(CELL_NUM);
	localparam logic [CLUSTER_W-1:0] THIS_CLUSTER = CLUSTER_W'(CLUSTER_NUM);
	localparam logic [CLUSTER_W-1:0] STEP = CLUSTER_W'(CHAIN_CLUSTER_STEP);
	wire at_end = THIS_CELL == LAST_CELL;
	assign carry_next_cell = at_end ? 4'h1 : THIS_CELL + 4'h1;
	assign carry_next_cluster = at_end ? THIS_CLUSTER + STEP :
		THIS_CLUSTER;

	wire [1:0] extra_cells = emulated ? EMUL_EXTRA_CELLS : 2'h0;
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[STAT_Q] = q_r;
		status_w[STAT_COMB] = casc_w;
		status_w[STAT_CARRY] = carry_w;
		status_w[STAT_CASC] = casc_w;
		status_w[STAT_UNKNOWN] = unknown_r;
		status_w[STAT_XTRA_LSB +: 2] = extra_cells;
	end

	// checks
	lut_normal_a: assert property (@(posedge clk) disable iff (!nrst)
		(mode == MODE_NORMAL && !casc_en) |->
		cell_out.comb_out == lut_r[cell_in.data])
		else $error("normal mode output is not the table entry");

	carry_feed_a: assert property (@(posedge clk) disable iff (!nrst)
		(mode == MODE_ARITH) |-> cell_out.carry_out ==
		lut_r[{1'b1, cell_in.carry_in, cell_in.data[1:0]}])
		else $error("arithmetic carry does not follow table");

	sclr_prio_a: assert property (@(posedge clk) disable iff (!nrst)
		(is_counter && clk_en && sync_clear && cluster_ctl.sync_load &&
		!dev_clear && !a_act) |=> !q_r)
		else $error("sync clear lost to load");

	sload_data_a: assert property (@(posedge clk) disable iff (!nrst)
		(is_counter && clk_en && !sync_clear && cluster_ctl.sync_load &&
		!dev_clear && !a_act) |=> q_r == $past(cell_in.data[2]))
		else $error("sync load did not capture load data");

	devclr_a: assert property (@(posedge clk) disable iff (!nrst)
		(dclr_en && !device_wide_clear_n)[*3] ##0 !preset_kind
		|=> !q_r)
		else $error("device clear did not clear register");

	preset_devclr_a: assert property (@(posedge clk) disable iff (!nrst)
		(dev_clear && preset_kind) |=> q_r)
		else $error("preset register not set by device clear");

	accum_a: assert property (@(posedge clk) disable iff (!nrst)
		(clk_en && !dev_clear && !a_act && !is_counter) |=>
		q_r == $past(casc_w))
		else $error("register did not capture table output");

	chain_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
		at_end |-> carry_next_cluster == THIS_CLUSTER + STEP &&
		carry_next_cell == 4'h1)
		else $error("chain does not skip to alternate cluster");

	unknown_flag_a: assert property (@(posedge clk) disable iff (!nrst)
		(dev_clear && aclr_mode == ACLR_LOAD) |=> unknown_r)
		else $error("emulated load state not marked undefined");

	extra_cells_a: assert property (@(posedge clk) disable iff (!nrst)
		emulated |-> status_w[STAT_XTRA_LSB +: 2] == 2'h3)
		else $error("emulation cell cost wrong");

	async_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		(aclr_mode == ACLR_CLEAR && c1 && !dev_clear) |=> !q_r)
		else $error("cluster clear did not clear register");

	sink_a: assert property (@(posedge clk) disable iff (!nrst)
		(mode == MODE_CARRY_SINK && !casc_en) |->
		cell_out.comb_out == cell_in.carry_in)
		else $error("final carry not delivered to output");

	casc_gate_a: assert property (@(posedge clk) disable iff (!nrst)
		(casc_en && !cell_in.cascade_in) |-> !cell_out.cascade_out)
		else $error("cascade input did not gate the output");

	counter_half_a: assert property (@(posedge clk) disable iff (!nrst)
		(mode == MODE_COUNTER && !casc_en) |-> cell_out.comb_out ==
		lut_r[{1'b0, cell_in.carry_in, cell_in.data[1], q_r}])
		else $error("counter data half does not follow table");

	casc_override_a: assert property (@(posedge clk) disable iff (!nrst)
		(is_counter && casc_en && clk_en && sync_clear && !dev_clear &&
		!a_act) |=> !q_r)
		else $error("cascade value beat sync clear");

	sclr_src_a: assert property (@(posedge clk) disable iff (!nrst)
		(is_counter && clk_en && sclr_global &&
		cluster_ctl.sync_clear_global && !dev_clear && !a_act) |=> !q_r)
		else $error("global sync clear not honoured");

	preset_line_a: assert property (@(posedge clk) disable iff (!nrst)
		(aclr_mode == ACLR_PRESET && c2 && !dev_clear) |=> q_r)
		else $error("cluster preset did not set register");

	async_load_a: assert property (@(posedge clk) disable iff (!nrst)
		(aclr_mode == ACLR_LOAD && c1 && !dev_clear) |=>
		q_r == $past(cell_in.data[3]))
		else $error("cluster load did not capture data");

	hold_noclk_a: assert property (@(posedge clk) disable iff (!nrst)
		(!clk_en && !dev_clear && !a_act) |=> $stable(q_r))
		else $error("register moved without a clock enable");

	devclr_sync_a: assert property (@(posedge clk) disable iff (!nrst)
		dev_clear |-> !$past(device_wide_clear_n, 2))
		else $error("device clear acted without the pin low");

	next_cell_a: assert property (@(posedge clk) disable iff (!nrst)
		!at_end |-> carry_next_cell == THIS_CELL + 4'h1 &&
		carry_next_cluster == THIS_CLUSTER)
		else $error("chain does not step to the next cell");

	unknown_clr_a: assert property (@(posedge clk) disable iff (!nrst)
		(unknown_r && clk_en && !dev_clear && !a_act) |=> !unknown_r)
		else $error("undefined flag not cleared by update");

endmodule : fabric_logic_cell

// ### verification/neighbour_cells.sv
`timescale 1ns/100ps
module neighbour_cells
(
	input wire logic [3:0] route_data,
	input wire logic lo_carry,
	input wire logic lo_cascade,
	input wire fabric_cell_pkg::cell_out_s from_cell,
	output fabric_cell_pkg::cell_in_s to_cell,
	output logic hi_carry
);
	import fabric_cell_pkg::*;

	// lower-order neighbour feeds both chains of the cell
	always_comb begin
		to_cell.data = route_data;
		to_cell.carry_in = lo_carry;
		to_cell.cascade_in = lo_cascade;
	end
	// higher-order neighbour takes the carry straight off the chain
	assign hi_carry = from_cell.carry_out;
endmodule : neighbour_cells

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
	import fabric_cell_pkg::*;
	logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, dclr_n = 1;
	logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = '0;
	logic [3:0] dat = '0, nxc;
	logic [7:0] nxg;
	logic lo_c = 0, lo_s = 0, hready, hresp, hi_c;
	cluster_ctl_s ctl = '0;
	cell_in_s cin;
	cell_out_s cout;
	int n_mismatch = 0, checks = 0;

	always #10 clk = ~clk;

	fabric_logic_cell dut (.clk(clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hrdata(hrdata), .hresp(hresp), .cell_in(cin), .cluster_ctl(ctl),
		.device_wide_clear_n(dclr_n), .cell_out(cout),
		.carry_next_cell(nxc), .carry_next_cluster(nxg));
	neighbour_cells nb (.route_data(dat), .lo_carry(lo_c),
		.lo_cascade(lo_s), .from_cell(cout), .to_cell(cin),
		.hi_carry(hi_c));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// outputs read right after an edge still show the pre-edge value
	task step(input int n);
		repeat (n) @(posedge clk);
	endtask : step

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task setup(input logic [15:0] lut, input logic [31:0] cfg);
		bus(1'b1, OFF_LUT, {16'h0, lut});
		bus(1'b1, OFF_CFG, cfg);
	endtask : setup

	task t_regs;
		bus(1'b0, OFF_LUT, 32'h0);
		chk(rd, {16'h0, LUT_RST});
		bus(1'b0, OFF_CFG, 32'h0);
		chk(rd, CFG_RST);
		bus(1'b1, 8'h0c, 32'hffff_ffff);
		bus(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		chk(nxc, 4'h2);
		chk(nxg, 8'h0);
		$display("registers done");
	endtask : t_regs

	task t_table;
		setup(16'h6ac5, 32'h0000_0400);
		for (int i = 0; i < 16; i++) begin
			dat <= i[3:0];
			lo_c <= i[0];
			step(1);
			chk(cout.comb_out, 16'h6ac5 >> i & 1);
			chk(cout.carry_out, i[0]);
		end
		bus(1'b1, OFF_CFG, 32'h408);
		dat <= 4'h0;
		lo_s <= 1'b0;
		step(1);
		chk(cout.cascade_out, 1'b0);
		lo_s <= 1'b1;
		step(1);
		chk(cout.cascade_out, 1'b1);
		$display("table done");
	endtask : t_table

	task t_arith;
		setup(16'he896, 32'h0000_0401);
		ctl.clk_local <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			dat <= {2'b00, i[1:0]};
			lo_c <= i[2];
			step(2);
			chk(cout.comb_out, ^i[2:0]);
			chk(cout.reg_out, ^i[2:0]);
			chk(hi_c, i[0] & i[1] | i[2] & (i[0] | i[1]));
		end
		$display("arith done");
	endtask : t_arith

	task t_count;
		setup(16'h0000, 32'h0000_0402);
		ctl.sync_load <= 1'b1;
		dat <= 4'h4;
		step(2);
		chk(cout.reg_out, 1'b1);
		ctl.sync_clear_local <= 1'b1;
		step(2);
		chk(cout.reg_out, 1'b0);
		ctl <= '0;
		$display("counter done");
	endtask : t_count

	task t_devclr;
		setup(16'hffff, 32'h0000_0420);
		dclr_n <= 1'b0;
		step(4);
		chk(cout.reg_out, 1'b1);
		bus(1'b1, OFF_CFG, 32'h410);
		step(2);
		chk(cout.reg_out, 1'b0);
		bus(1'b1, OFF_CFG, 32'h440);
		bus(1'b0, OFF_STAT, 32'h0);
		chk(rd[4], 1'b1);
		chk(rd[6:5], 2'h3);
		dclr_n <= 1'b1;
		$display("device clear done");
	endtask : t_devclr

	task conclude;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	initial begin
		#100us;
		n_mismatch++;
		$display("BAD %0t timeout", $time);
		conclude;
	end

	initial begin
		step(4);
		nrst <= 1'b1;
		step(1);
		t_regs;
		t_table;
		t_arith;
		t_count;
		t_devclr;
		conclude;
	end
endmodule : testbench

// ### verification/testbench_unused.sv
`timescale 1ns/100ps
